// >>> core/mbi_pkg.sv
// package for the main memory and rom bus interface
// assumes one 200 MHz clock and firmware-driven configuration ports
package mbi_pkg;
   localparam int MBI_DATA_W = 16;
   localparam int MBI_ADDR_W = 24;
   localparam int MBI_MA_W = 12;
   // dram strobe timing in ns, converted to cycles at 5 ns
   localparam int MBI_CLK_NS = 5;
   localparam int MBI_T_RAS_CAS_NS = 20;
   localparam int MBI_T_CAS_NS = 15;
   localparam int MBI_T_PRE_NS = 10;
   localparam int MBI_RC_CYC =
      (MBI_T_RAS_CAS_NS + MBI_CLK_NS - 1) / MBI_CLK_NS;
   localparam int MBI_CAS_CYC = (MBI_T_CAS_NS + MBI_CLK_NS - 1) / MBI_CLK_NS;
   localparam int MBI_PRE_CYC = (MBI_T_PRE_NS + MBI_CLK_NS - 1) / MBI_CLK_NS;
   localparam int MBI_CNT_W = 4;
   // address fields
   localparam int MBI_ROW_LSB = 12;
   localparam int MBI_BANK_BIT = 23;
   localparam logic [7:0] MBI_BOOT_SEG = 8'hFF;
   localparam logic [7:0] MBI_SEG_0F = 8'h0F;
   localparam logic [7:0] MBI_SEG_0E = 8'h0E;
   localparam logic [7:0] MBI_SEG_0D = 8'h0D;
   localparam logic [7:0] MBI_SEG_0C = 8'h0C;
   localparam logic [7:0] MBI_SEG_0A = 8'h0A;
   localparam int MBI_SEG_LSB = 16;
   // inactive pin levels
   localparam logic [3:0] MBI_STRB4_OFF = 4'hF;
   localparam logic [1:0] MBI_STRB2_OFF = 2'h3;

   // cycle kinds presented by the cpu side
   typedef enum logic [1:0]
   {
      MBI_CYC_MAIN = 2'b00,
      MBI_CYC_EXT = 2'b01,
      MBI_CYC_INTIO = 2'b10
   } mbi_kind_t;

   // one access request
   typedef struct packed
   {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic write;
      logic [1:0] byte_en;
      mbi_kind_t kind;
   } mbi_req_t;

   // rom decode setup
   typedef struct packed
   {
      logic bios_paged;
      logic [4:0] bios_range_en;
      logic os_paged;
      logic [7:0] os_seg;
      logic os_win_hit;
      logic bios_win_hit;
   } mbi_rom_cfg_t;
endpackage

// >>> core/mbi_rom_decode.sv
// rom chip select decoder, combinational
// assumes addresses are stable while a cycle is in flight
`timescale 1ns/1ps
module mbi_rom_decode
   import mbi_pkg::*;
(
   // request address and setup
   input wire logic [23:0] addr_i,
   input wire logic active_i,
   input wire mbi_rom_cfg_t cfg_i,
   // selects, active high here
   output logic bios_hit_o,
   output logic os_hit_o
);
   logic [7:0] seg;
   logic direct_bios;
   assign seg = addr_i[MBI_SEG_LSB +: 8];
   // enabled fixed ranges for direct bios mapping
   assign direct_bios = (cfg_i.bios_range_en[0] && seg == MBI_SEG_0F)
      || (cfg_i.bios_range_en[1] && seg == MBI_SEG_0E)
      || (cfg_i.bios_range_en[2] && seg == MBI_SEG_0D)
      || (cfg_i.bios_range_en[3] && seg == MBI_SEG_0C)
      || (cfg_i.bios_range_en[4] && seg == MBI_SEG_0A);
   // boot segment always selects bios; paged mode uses window hit
   assign bios_hit_o = active_i && ((seg == MBI_BOOT_SEG)
      || (cfg_i.bios_paged ? cfg_i.bios_win_hit
      : direct_bios));
   assign os_hit_o = active_i && (cfg_i.os_paged ? cfg_i.os_win_hit
      : (seg == cfg_i.os_seg));
endmodule

// >>> core/mbi_mem_if.sv
// main memory and rom bus interface, pin side
// assumes one synchronous active-low reset and a single requester
`timescale 1ns/1ps
module mbi_mem_if
   import mbi_pkg::*;
#(
   parameter int DATA_W = MBI_DATA_W
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // configuration from firmware
   input wire logic sram_mode_i,
   input wire mbi_rom_cfg_t rom_cfg_i,
   // request side
   input wire logic req_valid_i,
   input wire mbi_req_t req_i,
   output logic req_ready_o,
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   // memory pins
   output logic [MBI_MA_W-1:0] mem_addr_lines_o,
   output logic [11:0] sys_addr_lower_o,
   output logic [1:0] row_strobe_n_o,
   output logic col_strobe_bank1_hi_o,
   output logic col_strobe_bank1_lo_o,
   output logic col_strobe_bank0_hi_o,
   output logic col_strobe_bank0_lo_o,
   output logic mem_write_strobe_n_o,
   output logic bios_rom_select_n_o,
   output logic os_rom_select_n_o,
   // data bus, enable low while driving
   input wire logic [DATA_W-1:0] sys_data_bus_i,
   output logic [DATA_W-1:0] sys_data_bus_o,
   output logic sys_data_bus_oe_n_o
);
   typedef enum logic [2:0]
   {
      MBI_IDLE = 3'b000,
      MBI_ROW = 3'b001,
      MBI_COL = 3'b010,
      MBI_PRE = 3'b011,
      MBI_SRAM = 3'b100
   } mbi_state_t;

   mbi_state_t state_r;
   mbi_req_t req_r;
   logic [MBI_CNT_W-1:0] cnt_r;
   logic bios_hit;
   logic os_hit;
   logic [3:0] cas_n_r;
   logic [3:0] byte_lane;
   logic bank;

   // strobe lane order: bank1 hi, bank1 lo, bank0 hi, bank0 lo
   function automatic logic [3:0] lanes(input logic bk, input logic [1:0] be);
      lanes = bk ? {be[1], be[0], 2'b00} : {2'b00, be[1], be[0]};
   endfunction

   assign bank = req_r.addr[MBI_BANK_BIT];
   assign byte_lane = lanes(bank, req_r.byte_en);
   assign col_strobe_bank1_hi_o = cas_n_r[3];
   assign col_strobe_bank1_lo_o = cas_n_r[2];
   assign col_strobe_bank0_hi_o = cas_n_r[1];
   assign col_strobe_bank0_lo_o = cas_n_r[0];

   mbi_rom_decode u_rom
   (
      .addr_i(req_i.addr),
      .active_i(req_valid_i && req_ready_o && req_i.kind == MBI_CYC_EXT),
      .cfg_i(rom_cfg_i),
      .bios_hit_o(bios_hit),
      .os_hit_o(os_hit)
   );

   // access sequencer; mode taken per cycle from firmware port
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         state_r <= MBI_IDLE;
         req_r <= '0;
         cnt_r <= '0;
         req_ready_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         case (state_r)
            MBI_IDLE:
            begin
               req_ready_o <= 1'b1;
               if (req_valid_i && req_ready_o)
               begin
                  req_r <= req_i;
                  req_ready_o <= 1'b0;
                  cnt_r <= '0;
                  if (req_i.kind == MBI_CYC_MAIN && !sram_mode_i)
                     state_r <= MBI_ROW;
                  else
                     state_r <= MBI_SRAM;
               end
            end
            MBI_ROW:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == MBI_CNT_W'(MBI_RC_CYC - 1))
               begin
                  cnt_r <= '0;
                  state_r <= MBI_COL;
               end
            end
            MBI_COL:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == MBI_CNT_W'(MBI_CAS_CYC - 1))
               begin
                  cnt_r <= '0;
                  state_r <= MBI_PRE;
               end
            end
            MBI_PRE:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == MBI_CNT_W'(MBI_PRE_CYC - 1))
               begin
                  done_o <= 1'b1;
                  state_r <= MBI_IDLE;
               end
            end
            MBI_SRAM:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == MBI_CNT_W'(MBI_CAS_CYC - 1))
               begin
                  done_o <= 1'b1;
                  state_r <= MBI_IDLE;
               end
            end
            default:
               state_r <= MBI_IDLE;
         endcase
      end
   end

   // row strobe held from row phase until precharge entry
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
         row_strobe_n_o <= MBI_STRB2_OFF;
      else if (state_r == MBI_IDLE && req_valid_i && req_ready_o
         && req_i.kind == MBI_CYC_MAIN && !sram_mode_i)
         row_strobe_n_o <= req_i.addr[MBI_BANK_BIT] ? 2'b01
            : 2'b10;
      else if (state_r == MBI_COL && cnt_r == MBI_CNT_W'(MBI_CAS_CYC - 1))
         row_strobe_n_o <= MBI_STRB2_OFF;
   end

   // column strobes in dram, byte selects in sram mode
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
         cas_n_r <= MBI_STRB4_OFF;
      else if (state_r == MBI_ROW && cnt_r == MBI_CNT_W'(MBI_RC_CYC - 1))
         cas_n_r <= ~byte_lane;
      else if (state_r == MBI_IDLE && req_valid_i && req_ready_o
         && req_i.kind == MBI_CYC_MAIN && sram_mode_i)
         cas_n_r <= ~lanes(req_i.addr[MBI_BANK_BIT],
            req_i.byte_en);
      else if ((state_r == MBI_COL || state_r == MBI_SRAM)
         && cnt_r == MBI_CNT_W'(MBI_CAS_CYC - 1))
         cas_n_r <= MBI_STRB4_OFF;
   end

   // address lines: row, then column, else unmultiplexed
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         mem_addr_lines_o <= '0;
         sys_addr_lower_o <= '0;
      end
      else if (state_r == MBI_IDLE && req_valid_i && req_ready_o)
      begin
         sys_addr_lower_o <= req_i.addr[11:0];
         if (req_i.kind == MBI_CYC_MAIN && !sram_mode_i)
            mem_addr_lines_o <= req_i.addr[MBI_ROW_LSB +: MBI_MA_W];
         else if (req_i.kind == MBI_CYC_MAIN)
            mem_addr_lines_o <= req_i.addr[23:12];
         else
            mem_addr_lines_o <= {req_i.addr[12], req_i.addr[13],
               req_i.addr[23:14]};
      end
      else if (state_r == MBI_ROW && cnt_r == MBI_CNT_W'(MBI_RC_CYC - 1))
         mem_addr_lines_o <= {1'b0, req_r.addr[11:1]};
   end

   // write strobe and data direction
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         mem_write_strobe_n_o <= 1'b1;
         sys_data_bus_o <= '0;
         sys_data_bus_oe_n_o <= 1'b1;
      end
      else if (state_r == MBI_IDLE && req_valid_i && req_ready_o)
      begin
         sys_data_bus_o <= DATA_W'(req_i.wdata);
         sys_data_bus_oe_n_o <= !req_i.write;
         mem_write_strobe_n_o <= !(req_i.write
            && req_i.kind == MBI_CYC_MAIN);
      end
      else if (done_o || state_r == MBI_PRE)
      begin
         mem_write_strobe_n_o <= 1'b1;
         sys_data_bus_oe_n_o <= 1'b1;
      end
   end

   // rom selects registered with the cycle; read data capture
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         bios_rom_select_n_o <= 1'b1;
         os_rom_select_n_o <= 1'b1;
         rdata_o <= '0;
      end
      else
      begin
         if (state_r == MBI_IDLE && req_valid_i && req_ready_o)
         begin
            bios_rom_select_n_o <= !bios_hit;
            os_rom_select_n_o <= !(os_hit && !bios_hit);
         end
         else if (state_r == MBI_SRAM && cnt_r == MBI_CNT_W'(MBI_CAS_CYC - 1))
         begin
            bios_rom_select_n_o <= 1'b1;
            os_rom_select_n_o <= 1'b1;
         end
         if (!req_r.write && ((state_r == MBI_COL || state_r == MBI_SRAM)
            && cnt_r == MBI_CNT_W'(MBI_CAS_CYC - 1)))
            rdata_o <= sys_data_bus_i;
      end
   end

   // in dram mode, row strobe must be low whenever any column strobe is low
   AST_RAS_COVERS_CAS: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      (!sram_mode_i && cas_n_r != MBI_STRB4_OFF && state_r == MBI_COL)
      |-> row_strobe_n_o != MBI_STRB2_OFF)
      else $error("column strobe without row strobe");
   sequence s_row_start;
      state_r == MBI_ROW && cnt_r == '0;
   endsequence
   AST_CAS_AFTER_ROW: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      s_row_start |-> ##[1:8] (cas_n_r != MBI_STRB4_OFF))
      else $error("column strobe late");
   // lines hold the row, then the column, while each phase runs
   AST_ROW_ADDR: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      state_r == MBI_ROW
      |-> mem_addr_lines_o == req_r.addr[MBI_ROW_LSB +: MBI_MA_W])
      else $error("row address not on lines");
   AST_COL_ADDR: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      state_r == MBI_COL
      |-> mem_addr_lines_o == {1'b0, req_r.addr[11:1]})
      else $error("column address not on lines");
   AST_WRITE_DRIVES: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      !mem_write_strobe_n_o |-> !sys_data_bus_oe_n_o)
      else $error("write strobe without data drive");
   AST_ONE_ROW: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      row_strobe_n_o != 2'b00)
      else $error("both row strobes low");
   AST_DONE_IDLE: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      done_o |-> state_r == MBI_IDLE && row_strobe_n_o == MBI_STRB2_OFF)
      else $error("cycle ended with row open");
   AST_SRAM_NO_RAS: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      state_r == MBI_SRAM |-> row_strobe_n_o == MBI_STRB2_OFF)
      else $error("row strobe in sram cycle");
   AST_ROMS_EXCL: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      !(!bios_rom_select_n_o && !os_rom_select_n_o))
      else $error("both rom selects low");
   AST_BOOT_SEL: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      (state_r == MBI_IDLE && req_valid_i && req_ready_o
      && req_i.kind == MBI_CYC_EXT && req_i.addr[23:16] == MBI_BOOT_SEG)
      |=> !bios_rom_select_n_o)
      else $error("boot segment missed bios select");
endmodule

// >>> tb/mbi_mem_model.sv
// memory devices on the far side: dram and sram
// assumes strobes from the interface; the data bus has no pull
`timescale 1ns/1ps
module mbi_mem_model (
   // strobes and address
   input wire logic clock_i,
   input wire logic [11:0] ma_i,
   input wire logic [11:0] lo_i,
   input wire logic [1:0] row_n_i,
   input wire logic [3:0] cas_n_i,
   input wire logic we_n_i,
   // data bus
   input wire logic [15:0] d_i,
   output logic [15:0] d_o
);
   logic [15:0] mem [logic [23:0]];
   logic [11:0] row_r;
   logic [23:0] key;
   logic hi;
   logic lo;
   initial d_o = 16'h0000;
   // byte lanes of either bank
   assign hi = !(cas_n_i[3] & cas_n_i[1]);
   assign lo = !(cas_n_i[2] & cas_n_i[0]);
   // no row strobe means sram addressing
   assign key = (&row_n_i) ? {1'b0, ma_i, lo_i[11:1]}
      : {1'b0, row_r, ma_i[10:0]};
   // row taken while row low and columns idle
   always @(posedge clock_i)
   begin
      if (row_n_i != 2'b11 && cas_n_i == 4'hF)
         row_r <= ma_i;
   end
   // writes per byte; reads a cycle late, else a pattern that changes
   always @(posedge clock_i)
   begin
      if (!we_n_i && (hi || lo))
      begin
         if (!mem.exists(key))
            mem[key] = 16'h0000;
         if (hi)
            mem[key][15:8] = d_i[15:8];
         if (lo)
            mem[key][7:0] = d_i[7:0];
      end
      if (we_n_i && (hi || lo) && mem.exists(key))
         d_o <= mem[key];
      else
         d_o <= ~d_o;
   end
endmodule

// >>> tb/mbi_mem_if_tb.sv
// self-checking bench for the memory bus interface
// assumes the memory model is compiled before this file
`timescale 1ns/1ps
module mbi_mem_if_tb;
   import mbi_pkg::*;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic sram_mode_i = 1'b0;
   mbi_rom_cfg_t rom_cfg_i = '0;
   logic req_valid_i = 1'b0;
   mbi_req_t req_i = '0;
   logic req_ready_o, done_o, we_n, bios_n, os_n, oe_n;
   logic [15:0] rdata_o, d_in, d_out;
   logic [11:0] ma, lo, ma_s, ma_c, lo_s;
   logic [1:0] row_n, row_acc;
   logic [3:0] cas_acc;
   wire [3:0] cas_n;
   logic we_s, oe_s, bios_s, os_s, order_bad;
   logic [7:0] segs [5];
   int n_mismatch = 0;
   int n_tests = 0;
   mbi_rom_cfg_t c;
   mbi_mem_if u_mbi_mem_if (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .sram_mode_i(sram_mode_i), .rom_cfg_i(rom_cfg_i),
      .req_valid_i(req_valid_i), .req_i(req_i),
      .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
      .mem_addr_lines_o(ma), .sys_addr_lower_o(lo),
      .row_strobe_n_o(row_n), .col_strobe_bank1_hi_o(cas_n[3]),
      .col_strobe_bank1_lo_o(cas_n[2]), .col_strobe_bank0_hi_o(cas_n[1]),
      .col_strobe_bank0_lo_o(cas_n[0]), .mem_write_strobe_n_o(we_n),
      .bios_rom_select_n_o(bios_n), .os_rom_select_n_o(os_n),
      .sys_data_bus_i(d_in), .sys_data_bus_o(d_out),
      .sys_data_bus_oe_n_o(oe_n));
   mbi_mem_model u_mbi_mem_model (.clock_i(clock_i), .ma_i(ma), .lo_i(lo),
      .row_n_i(row_n), .cas_n_i(cas_n), .we_n_i(we_n), .d_i(d_out),
      .d_o(d_in));
   // 200 MHz clock
   initial
   begin
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one request, pins watched every cycle until done
   task automatic req(input logic [23:0] a, input logic [15:0] d,
      input logic w, input logic [1:0] be, input mbi_kind_t k);
      int n;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 40)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
      req_i = '{addr: a, wdata: d, write: w, byte_en: be, kind: k};
      req_valid_i = 1'b1;
      {cas_acc, row_acc} = 6'h3F;
      {we_s, oe_s, bios_s, os_s, order_bad} = 5'h00;
      @(posedge clock_i);
      #1;
      req_valid_i = 1'b0;
      n = 1;
      while (done_o !== 1'b1 && n < 40)
      begin
         cas_acc &= cas_n;
         row_acc &= row_n;
         we_s |= ~we_n;
         oe_s |= ~oe_n;
         bios_s |= ~bios_n;
         os_s |= ~os_n;
         if (cas_n != 4'hF && (&row_n) && !sram_mode_i)
            order_bad = 1'b1;
         if (cas_n != 4'hF)
            ma_c = ma;
         if (n == 2)
            {ma_s, lo_s} = {ma, lo};
         @(posedge clock_i);
         #1;
         n++;
      end
      chk(24'(n < 40), 24'h1);
      @(posedge clock_i);
      #1;
      chk(24'(done_o), 24'h0);
   endtask
   // write then read back one word of main memory
   task automatic main_rw(input logic [23:0] a, input logic [15:0] d,
      input logic [1:0] be, input logic [15:0] e);
      req(a, d, 1'b1, be, MBI_CYC_MAIN);
      chk(24'(cas_acc), 24'(a[23] ? {~be, 2'b11} : {2'b11, ~be}));
      chk(24'({we_s, oe_s, order_bad}), 24'h6);
      chk(24'(ma_s), 24'(a[23:12]));
      if (sram_mode_i)
         chk(24'(lo_s[11:1]), 24'(a[11:1]));
      else
         chk(24'({ma_c[10:0], row_acc}),
            24'({a[11:1], ~a[23], a[23]}));
      req(a, 16'h0000, 1'b0, 2'b11, MBI_CYC_MAIN);
      chk(24'({we_s, oe_s}), 24'h0);
      chk(24'(rdata_o), 24'(e));
   endtask
   // rom area access with expected selects
   task automatic ext(input logic [23:0] a, input logic b, input logic o);
      rom_cfg_i = c;
      req(a, 16'h0000, 1'b0, 2'b11, MBI_CYC_EXT);
      chk(24'({bios_s, os_s}), 24'({b, o}));
      chk(24'(ma_s), 24'({a[12], a[13], a[23:14]}));
      chk(24'(cas_acc), 24'hF);
   endtask
   // hang guard, far beyond the expected run
   initial
   begin
      #100000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      segs = '{MBI_SEG_0F, MBI_SEG_0E, MBI_SEG_0D, MBI_SEG_0C, MBI_SEG_0A};
      repeat (3) @(posedge clock_i);
      #1;
      chk(24'({row_n, cas_n, we_n, bios_n, os_n, oe_n}), 24'h3FF);
      rst_b_i = 1'b1;
      main_rw(24'h01_2346, 16'hA55A, 2'b11, 16'hA55A);
      main_rw(24'h81_2346, 16'h1234, 2'b11, 16'h1234);
      main_rw(24'h81_2346, 16'hAB00, 2'b10, 16'hAB34);
      main_rw(24'h81_2346, 16'h00CD, 2'b01, 16'hABCD);
      $display("dram test done");
      sram_mode_i = 1'b1;
      main_rw(24'h00_4102, 16'h5AA5, 2'b11, 16'h5AA5);
      main_rw(24'h80_4102, 16'hC3C3, 2'b11, 16'hC3C3);
      main_rw(24'h80_4102, 16'h9900, 2'b10, 16'h99C3);
      $display("sram test done");
      for (int i = 0; i < 5; i++)
      begin
         c = '0;
         c.bios_range_en = 5'h01 << i;
         ext({segs[i], 16'h1234}, 1'b1, 1'b0);
         c.bios_range_en = ~(5'h01 << i);
         ext({segs[i], 16'hFFFF}, 1'b0, 1'b0);
      end
      c = '0;
      ext(24'hFF_0000, 1'b1, 1'b0);
      ext(24'hFF_FFFF, 1'b1, 1'b0);
      ext(24'hFE_FFFF, 1'b0, 1'b0);
      c.os_seg = 8'h40;
      ext(24'h40_8000, 1'b0, 1'b1);
      ext(24'h41_0000, 1'b0, 1'b0);
      c = '0;
      c.bios_paged = 1'b1;
      c.bios_win_hit = 1'b1;
      ext(24'h30_0000, 1'b1, 1'b0);
      c.bios_win_hit = 1'b0;
      ext(24'h30_0000, 1'b0, 1'b0);
      c = '0;
      c.os_paged = 1'b1;
      c.os_win_hit = 1'b1;
      ext(24'h50_2000, 1'b0, 1'b1);
      c = '0;
      req(24'hFF_0060, 16'h0000, 1'b0, 2'b11, MBI_CYC_INTIO);
      chk(24'({bios_s, os_s, we_s, cas_acc}), 24'h0F);
      $display("rom test done");
      summarize();
   end
endmodule
